// ### pscp_top.sv
// device side of the passive serial configuration port
`timescale 1ns/100ps
module pscp_top #(
   parameter int WORD_W = 8,
   parameter int NUM_WORDS = 16,
   parameter int STATUS_LOW_CYC = pscp_pkg::STATUS_MIN_CYC,
   parameter int INIT_OSC_CYC = pscp_pkg::INIT_MIN_CYC,
   parameter int USR_INIT_CYC = pscp_pkg::USR_INIT_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic reconfig_request_line_n,
   input wire logic device_status_line_n_in,
   output logic device_status_line_n_out,
   output logic device_status_line_n_oe,
   input wire logic configuration_done_line_in,
   output logic configuration_done_line_out,
   output logic configuration_done_line_oe,
   output logic init_complete_line_n_out,
   output logic init_complete_line_n_oe,
   input wire logic serial_config_clock,
   input wire logic serial_config_bit,
   input wire logic user_init_clock,
   output logic [WORD_W-1:0] cfg_data,
   output logic cfg_valid,
   input wire logic cfg_ready,
   output logic user_mode,
   output logic user_io_enable,
   output logic user_io_bit,
   output logic config_error
);

   localparam int BIT_W = $clog2(WORD_W + 1);
   localparam int WRD_W = $clog2(NUM_WORDS + 1);

   generate
      if (WORD_W < pscp_pkg::OPT_W || NUM_WORDS < 1) begin : g_bad_size
         $error("word width or word count too small");
      end
      if (STATUS_LOW_CYC < 1 || STATUS_LOW_CYC > pscp_pkg::STATUS_MAX_CYC) begin : g_bad_status
         $error("status low count out of range");
      end
      if (INIT_OSC_CYC < 1 || INIT_OSC_CYC > pscp_pkg::INIT_MAX_CYC) begin : g_bad_osc
         $error("oscillator init count out of range");
      end
      if (USR_INIT_CYC < 1 || USR_INIT_CYC + pscp_pkg::USR_WAIT_CYC >= 2 ** pscp_pkg::CNT_W) begin : g_bad_usr
         $error("user clock init count out of range");
      end
      if (pscp_pkg::SYNC_LAT_CYC > pscp_pkg::REQ_TO_LOW_CYC) begin : g_bad_lat
         $error("request response too slow");
      end
      // the shared counter must reach the longest documented delay
      if (pscp_pkg::STATUS_MAX_CYC >= 2 ** pscp_pkg::CNT_W || pscp_pkg::INIT_MAX_CYC >= 2 ** pscp_pkg::CNT_W) begin : g_bad_cnt
         $error("counter too narrow for the longest delay");
      end
      if (pscp_pkg::OPT_USER_IO >= pscp_pkg::OPT_W || pscp_pkg::OPT_SRC_LO + 1 >= pscp_pkg::OPT_W) begin : g_bad_opt
         $error("option field outside the option bits");
      end
      if (pscp_pkg::SCK_INIT_FALLS < 1) begin : g_bad_falls
         $error("serial clock init needs at least one fall");
      end
   endgenerate

   typedef struct packed {
      pscp_pkg::pscp_state_t st;
      logic [pscp_pkg::CNT_W-1:0] cnt;
      logic [WORD_W-1:0] shreg;
      logic [BIT_W-1:0] bitcnt;
      logic [WRD_W-1:0] wordcnt;
      logic sck_prev;
      logic usr_prev;
      logic armed;
      logic push;
      logic [pscp_pkg::OPT_W-1:0] opt;
      pscp_pkg::pscp_pins_t pins;
      logic user_mode;
      logic user_io_enable;
      logic user_io_bit;
      logic error;
   } pscp_top_state_t;

   pscp_top_state_t s;
   pscp_top_state_t next_s;
   pscp_pkg::pscp_inputs_t raw_in;
   pscp_pkg::pscp_inputs_t syn;
   logic buf_in_ready;
   logic sck_rise;
   logic sck_fall;
   logic usr_rise;

   assign raw_in.reconfig_n = reconfig_request_line_n;
   assign raw_in.status_n = device_status_line_n_in;
   assign raw_in.done = configuration_done_line_in;
   assign raw_in.sck = serial_config_clock;
   assign raw_in.sbit = serial_config_bit;
   assign raw_in.usr = user_init_clock;

   // every pin passes two flops; the request copy resets low, which the
   // power-on delay ignores
   pscp_sync #(
      .W($bits(pscp_pkg::pscp_inputs_t))
   ) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .async_in(raw_in),
      .sync_out(syn)
   );

   pscp_buf #(
      .W(WORD_W)
   ) u_buf (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(s.push),
      .in_data(s.shreg),
      .in_ready(buf_in_ready),
      .out_valid(cfg_valid),
      .out_data(cfg_data),
      .out_ready(cfg_ready)
   );

   // edges of the sampled link clocks
   assign sck_rise = syn.sck && !s.sck_prev;
   assign sck_fall = !syn.sck && s.sck_prev;
   assign usr_rise = syn.usr && !s.usr_prev;

   always_comb begin
      next_s = s;
      next_s.push = 1'b0;
      next_s.sck_prev = syn.sck;
      next_s.usr_prev = syn.usr;
      case (s.st)
         pscp_pkg::PSCP_POR: begin
            // power-on delay with status held low
            next_s.pins.status_oe = 1'b1;
            next_s.pins.done_oe = 1'b1;
            next_s.cnt = s.cnt + 1'b1;
            if (s.cnt >= pscp_pkg::CNT_W'(STATUS_LOW_CYC - 1)) begin
               next_s.st = pscp_pkg::PSCP_WAIT;
               next_s.pins.status_oe = 1'b0;
               next_s.cnt = '0;
            end
         end
         pscp_pkg::PSCP_CLEAR: begin
            next_s.pins.status_oe = 1'b1;
            next_s.pins.done_oe = 1'b1;
            if (s.cnt < pscp_pkg::CNT_W'(STATUS_LOW_CYC - 1)) begin
               next_s.cnt = s.cnt + 1'b1;
            end else if (syn.reconfig_n) begin
               // long request lows stretch the status low time
               next_s.st = pscp_pkg::PSCP_WAIT;
               next_s.pins.status_oe = 1'b0;
               next_s.cnt = '0;
            end
         end
         pscp_pkg::PSCP_WAIT: begin
            // an outside agent may still hold status low
            next_s.pins.status_oe = 1'b0;
            next_s.pins.done_oe = 1'b1;
            if (syn.status_n) begin
               next_s.st = pscp_pkg::PSCP_LOAD;
               next_s.bitcnt = '0;
               next_s.wordcnt = '0;
            end
         end
         pscp_pkg::PSCP_LOAD: begin
            if (sck_rise) begin
               next_s.shreg = {s.shreg[WORD_W-2:0], syn.sbit};
               next_s.bitcnt = s.bitcnt + 1'b1;
               if (s.bitcnt == BIT_W'(WORD_W - 1)) begin
                  next_s.bitcnt = '0;
                  if (!buf_in_ready) begin
                     // a word would be lost: flag the load as failed
                     next_s.st = pscp_pkg::PSCP_ERR;
                     next_s.error = 1'b1;
                     next_s.pins.status_oe = 1'b1;
                  end else begin
                     next_s.push = 1'b1;
                     next_s.wordcnt = s.wordcnt + 1'b1;
                     if (s.wordcnt == WRD_W'(NUM_WORDS - 1)) begin
                        // last word carries the option bits
                        next_s.opt = next_s.shreg[pscp_pkg::OPT_W-1:0];
                        next_s.pins.done_oe = 1'b0;
                        next_s.pins.init_oe = next_s.shreg[pscp_pkg::OPT_INIT_PIN_EN];
                        next_s.st = pscp_pkg::PSCP_INIT;
                        next_s.armed = 1'b0;
                        next_s.cnt = '0;
                     end
                  end
               end
            end
         end
         pscp_pkg::PSCP_INIT: begin
            case (s.opt[pscp_pkg::OPT_SRC_LO+:2])
               pscp_pkg::SRC_OSC: begin
                  // internal rate from the system clock
                  if (syn.done) begin
                     next_s.cnt = s.cnt + 1'b1;
                     if (s.cnt >= pscp_pkg::CNT_W'(INIT_OSC_CYC - 1)) begin
                        next_s.st = pscp_pkg::PSCP_USER;
                     end
                  end
               end
               pscp_pkg::SRC_USR: begin
                  if (syn.done) begin
                     if (s.cnt < pscp_pkg::CNT_W'(pscp_pkg::USR_WAIT_CYC)) begin
                        next_s.cnt = s.cnt + 1'b1;
                     end else if (usr_rise) begin
                        next_s.cnt = s.cnt + 1'b1;
                        if (s.cnt >= pscp_pkg::CNT_W'(pscp_pkg::USR_WAIT_CYC + USR_INIT_CYC - 1)) begin
                           next_s.st = pscp_pkg::PSCP_USER;
                        end
                     end
                  end
               end
               default: begin
                  // extra falling edges from the host; the fall that closes
                  // the last data bit comes before any rise and is skipped
                  if (sck_rise) begin
                     next_s.armed = 1'b1;
                  end
                  if (sck_fall && s.armed) begin
                     next_s.cnt = s.cnt + 1'b1;
                     if (s.cnt >= pscp_pkg::CNT_W'(pscp_pkg::SCK_INIT_FALLS - 1)) begin
                        next_s.st = pscp_pkg::PSCP_USER;
                     end
                  end
               end
            endcase
            if (next_s.st == pscp_pkg::PSCP_USER) begin
               next_s.pins.init_oe = 1'b0;
               next_s.user_mode = 1'b1;
               next_s.user_io_enable = s.opt[pscp_pkg::OPT_USER_IO];
            end
         end
         pscp_pkg::PSCP_USER: begin
            // serial clock no longer looked at
            next_s.pins.status_oe = 1'b0;
            next_s.pins.done_oe = 1'b0;
            next_s.pins.init_oe = 1'b0;
            next_s.user_io_bit = s.user_io_enable ? syn.sbit : 1'b0;
         end
         pscp_pkg::PSCP_ERR: begin
            // failed load: hold both lines low until the next request
            next_s.pins.status_oe = 1'b1;
            next_s.pins.done_oe = 1'b1;
            next_s.pins.init_oe = 1'b0;
         end
         default: begin
            next_s.st = pscp_pkg::PSCP_POR;
            next_s.cnt = '0;
         end
      endcase
      // request low aborts every state except the power-on delay and the clear state
      if (!syn.reconfig_n && s.st != pscp_pkg::PSCP_POR && s.st != pscp_pkg::PSCP_CLEAR) begin
         next_s.st = pscp_pkg::PSCP_CLEAR;
         next_s.pins.status_oe = 1'b1;
         next_s.pins.done_oe = 1'b1;
         next_s.pins.init_oe = 1'b0;
         next_s.cnt = '0;
         next_s.bitcnt = '0;
         next_s.wordcnt = '0;
         next_s.armed = 1'b0;
         next_s.push = 1'b0;
         next_s.user_mode = 1'b0;
         next_s.user_io_enable = 1'b0;
         next_s.user_io_bit = 1'b0;
         next_s.error = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s <= '0;
         s.st <= pscp_pkg::PSCP_POR;
         s.pins.status_oe <= 1'b1;
         s.pins.done_oe <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign device_status_line_n_out = s.pins.status_out;
   assign device_status_line_n_oe = s.pins.status_oe;
   assign configuration_done_line_out = s.pins.done_out;
   assign configuration_done_line_oe = s.pins.done_oe;
   assign init_complete_line_n_out = s.pins.init_out;
   assign init_complete_line_n_oe = s.pins.init_oe;
   assign user_mode = s.user_mode;
   assign user_io_enable = s.user_io_enable;
   assign user_io_bit = s.user_io_bit;
   assign config_error = s.error;

endmodule

// ### pscp_pkg.sv
// shared constants and types of the passive serial configuration port
package pscp_pkg;

   localparam int CLK_NS = 40;

   localparam int REQ_TO_LOW_NS = 600;
   localparam int REQ_TO_LOW_CYC = (REQ_TO_LOW_NS / CLK_NS) < 1 ? 1 : (REQ_TO_LOW_NS / CLK_NS);
   localparam int SYNC_LAT_CYC = 4;

   localparam int STATUS_MIN_US = 268;
   localparam int STATUS_MIN_CYC = (STATUS_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int STATUS_MAX_US = 1506;
   localparam int STATUS_MAX_CYC = (STATUS_MAX_US * 1000) / CLK_NS;

   localparam int INIT_MIN_US = 175;
   localparam int INIT_MIN_CYC = (INIT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int INIT_MAX_US = 437;
   localparam int INIT_MAX_CYC = (INIT_MAX_US * 1000) / CLK_NS;

   localparam int SCK_MIN_PERIOD_NS = 8;
   localparam int USR_WAIT_PERIODS = 4;
   localparam int USR_WAIT_NS = USR_WAIT_PERIODS * SCK_MIN_PERIOD_NS;
   localparam int USR_WAIT_CYC = (USR_WAIT_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 : (USR_WAIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int USR_INIT_CYCLES = 8576;
   localparam int SCK_INIT_FALLS = 2;

   localparam int CNT_W = 16;

   localparam int OPT_INIT_PIN_EN = 0;
   localparam int OPT_SRC_LO = 1;
   localparam int OPT_USER_IO = 3;
   localparam int OPT_W = 4;

   localparam logic [1:0] SRC_SCK = 2'h0;
   localparam logic [1:0] SRC_OSC = 2'h1;
   localparam logic [1:0] SRC_USR = 2'h2;

   typedef enum logic [6:0] {
      PSCP_POR = 7'h01,
      PSCP_CLEAR = 7'h02,
      PSCP_WAIT = 7'h04,
      PSCP_LOAD = 7'h08,
      PSCP_INIT = 7'h10,
      PSCP_USER = 7'h20,
      PSCP_ERR = 7'h40
   } pscp_state_t;

   typedef struct packed {
      logic status_out;
      logic status_oe;
      logic done_out;
      logic done_oe;
      logic init_out;
      logic init_oe;
   } pscp_pins_t;

   typedef struct packed {
      logic reconfig_n;
      logic status_n;
      logic done;
      logic sck;
      logic sbit;
      logic usr;
   } pscp_inputs_t;

endpackage

// ### pscp_sync.sv
// two-flop synchronisers, one per input bit
`timescale 1ns/100ps
module pscp_sync #(
   parameter int W = 6
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] stage1;

   generate
      for (genvar i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               stage1[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               stage1[i] <= async_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate

endmodule

// ### pscp_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module pscp_buf #(
   parameter int W = 8
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);

   typedef struct packed {
      logic [W-1:0] head;
      logic [W-1:0] tail;
      logic [1:0] cnt;
      logic valid;
   } pscp_buf_state_t;

   pscp_buf_state_t s;
   pscp_buf_state_t next_s;
   logic push;
   logic pop;

   assign in_ready = (s.cnt != 2'h2);
   // valid kept in its own flop so the port comes straight from a register
   assign out_valid = s.valid;
   assign out_data = s.head;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_s = s;
      case (s.cnt)
         2'h0: begin
            if (push) begin
               next_s.head = in_data;
               next_s.cnt = 2'h1;
            end
         end
         2'h1: begin
            if (push && pop) begin
               next_s.head = in_data;
            end else if (push) begin
               next_s.tail = in_data;
               next_s.cnt = 2'h2;
            end else if (pop) begin
               next_s.cnt = 2'h0;
            end
         end
         default: begin
            if (pop) begin
               next_s.head = s.tail;
               next_s.cnt = 2'h1;
            end
         end
      endcase
      next_s.valid = (next_s.cnt != 2'h0);
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule

// ### pscp_top_properties.sv
// assertions on the configuration port pins
`timescale 1ns/100ps
module pscp_top_properties #(
   parameter int WORD_W = 8,
   parameter int NUM_WORDS = 16,
   parameter int STATUS_LOW_CYC = 20
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic reconfig_request_line_n,
   input wire logic device_status_line_n_oe,
   input wire logic configuration_done_line_oe,
   input wire logic init_complete_line_n_oe,
   input wire logic serial_config_clock,
   input wire logic user_mode,
   input wire logic config_error
);
   logic [2:0] sck_s;
   logic [15:0] rises;
   logic [15:0] low_cyc;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   // serial clock rises since status release, status low length
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sck_s <= 3'h0;
         rises <= 16'h0;
         low_cyc <= 16'h0;
      end else begin
         sck_s <= {sck_s[1:0], serial_config_clock};
         rises <= device_status_line_n_oe ? 16'h0 : rises + 16'(sck_s[1] && !sck_s[2]);
         low_cyc <= device_status_line_n_oe ? low_cyc + 16'h1 : 16'h0;
      end
   end
   sequence s_req_in_user;
      $fell(reconfig_request_line_n) ##0 user_mode;
   endsequence
   sequence s_req_steady;
      reconfig_request_line_n [*3] ##0 user_mode;
   endsequence
   AST_REQ_LEAVES_USER:
      assert property (s_req_in_user |-> ##[1:15] !user_mode) else $error("user mode kept");
   AST_USER_RELEASED:
      assert property (user_mode |-> !device_status_line_n_oe && !configuration_done_line_oe
         && !init_complete_line_n_oe) else $error("line pulled in user mode");
   AST_STATUS_MIN_LOW:
      assert property ($fell(device_status_line_n_oe) |-> low_cyc >= STATUS_LOW_CYC - 1)
         else $error("status pulse short");
   AST_DONE_AFTER_ALL:
      assert property ($fell(configuration_done_line_oe) |-> ##[0:2] rises == WORD_W * NUM_WORDS)
         else $error("done released early");
   AST_SCK_IGNORED:
      assert property (s_req_steady |=> user_mode) else $error("user mode lost");
   AST_INIT_PIN_LOW:
      assert property (init_complete_line_n_oe |-> !user_mode && !configuration_done_line_oe)
         else $error("init pin misplaced");
   AST_DONE_LOW_FAST:
      assert property (s_req_in_user |-> ##[1:15] configuration_done_line_oe) else $error("done slow");
   AST_STATUS_LOW_FAST:
      assert property (s_req_in_user |-> ##[1:15] device_status_line_n_oe) else $error("status slow");
   AST_ERR_HOLDS:
      assert property (config_error |-> device_status_line_n_oe && configuration_done_line_oe)
         else $error("error without lines low");
endmodule
bind pscp_top pscp_top_properties #(.WORD_W(WORD_W), .NUM_WORDS(NUM_WORDS), .STATUS_LOW_CYC(STATUS_LOW_CYC))
   pscp_top_properties_inst (.clk_sys, .reset, .reconfig_request_line_n, .device_status_line_n_oe,
   .configuration_done_line_oe, .init_complete_line_n_oe, .serial_config_clock, .user_mode, .config_error);

// ### pscp_host.sv
// behavioural configuration host on the serial load pins
`timescale 1ns/100ps
module pscp_host (
   input wire logic status_wire,
   input wire logic done_wire,
   output logic req_n,
   output logic sck,
   output logic sbit,
   output logic usr
);
   initial begin
      req_n = 1'b1;
      sck = 1'b0;
      sbit = 1'b0;
      usr = 1'b0;
   end
   task automatic request();
      req_n = 1'b0;
      #2000;
      req_n = 1'b1;
   endtask
   task automatic wait_ready();
      wait (status_wire === 1'b1);
      #2001;
   endtask
   // msb first, bit set half a period before the rise
   task automatic send_word(input logic [7:0] w);
      int i;
      for (i = 7; i >= 0; i--) begin
         sbit = w[i];
         #160 sck = 1'b1;
         #160 sck = 1'b0;
      end
      sbit = ~sbit;
   endtask
   // clock parked low, never floating
   task automatic falls(input int n);
      repeat (n) begin
         #160 sck = 1'b1;
         #160 sck = 1'b0;
      end
   endtask
   always begin
      @(posedge done_wire);
      #41;
      while (done_wire === 1'b1) #50 usr = ~usr;
      usr = 1'b0;
   end
endmodule

// ### test_passive_serial_config_port.sv
// self-checking bench for the serial configuration port
`timescale 1ns/100ps
module test_passive_serial_config_port;
   localparam int NW = 4;
   localparam int SLC = 20;
   localparam int OSC = 20;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic cfg_ready = 1'b0;
   logic hold_sink = 1'b0;
   logic reconfig_request_line_n, serial_config_clock, serial_config_bit, user_init_clock;
   logic device_status_line_n_in, device_status_line_n_out, device_status_line_n_oe;
   logic configuration_done_line_in, configuration_done_line_out, configuration_done_line_oe;
   logic init_complete_line_n_out, init_complete_line_n_oe, cfg_valid, user_mode;
   logic user_io_enable, user_io_bit, config_error;
   logic [7:0] cfg_data;
   logic [7:0] got[$];
   int n_errors = 0;
   int checks_done = 0;
   assign device_status_line_n_in = device_status_line_n_oe ? device_status_line_n_out : 1'b1;
   assign configuration_done_line_in = configuration_done_line_oe ? configuration_done_line_out : 1'b1;
   pscp_top #(.NUM_WORDS(NW), .STATUS_LOW_CYC(SLC), .INIT_OSC_CYC(OSC), .USR_INIT_CYC(16)) pscp_top_inst (
      .clk_sys, .reset, .reconfig_request_line_n, .device_status_line_n_in, .device_status_line_n_out,
      .device_status_line_n_oe, .configuration_done_line_in, .configuration_done_line_out,
      .configuration_done_line_oe, .init_complete_line_n_out, .init_complete_line_n_oe, .serial_config_clock,
      .serial_config_bit, .user_init_clock, .cfg_data, .cfg_valid, .cfg_ready, .user_mode, .user_io_enable,
      .user_io_bit, .config_error);
   pscp_host host (.status_wire(device_status_line_n_in), .done_wire(configuration_done_line_in),
      .req_n(reconfig_request_line_n), .sck(serial_config_clock), .sbit(serial_config_bit),
      .usr(user_init_clock));
   always #20 clk_sys = ~clk_sys;
   // sink stalls every other cycle, or fully while held
   always @(posedge clk_sys) begin
      if (cfg_valid === 1'b1 && cfg_ready === 1'b1) got.push_back(cfg_data);
      #1 cfg_ready <= !hold_sink && !cfg_ready;
   end
   task automatic chk(input logic [7:0] a, input logic [7:0] b);
      checks_done++;
      if (a !== b) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_um(input int lim);
      int k;
      for (k = 0; k < lim && user_mode !== 1'b1; k++) cyc(1);
   endtask
   function automatic logic [7:0] wval(input int i, input logic [3:0] opt);
      return (i == NW - 1) ? {4'h3, opt} : {i[3:0], 4'hA};
   endfunction
   task automatic t_power_up();
      int k;
      cyc(SLC - 2);
      chk(device_status_line_n_oe, 1'b1);
      for (k = 0; k < 20 && device_status_line_n_in !== 1'b1; k++) cyc(1);
      chk(device_status_line_n_in, 1'b1);
      chk(configuration_done_line_oe, 1'b1);
   endtask
   task automatic t_config(input logic [3:0] opt);
      int i;
      got.delete();
      host.wait_ready();
      for (i = 0; i < NW; i++) begin
         chk(configuration_done_line_oe, 1'b1);
         host.send_word(wval(i, opt));
      end
      cyc(2);
      chk(configuration_done_line_oe, 1'b0);
      chk(init_complete_line_n_oe, opt[0]);
      chk(init_complete_line_n_out, 1'b0);
      chk(user_mode, 1'b0);
      case (opt[2:1])
         2'h1: begin
            cyc(OSC - 3);
            chk(user_mode, 1'b0);
            wait_um(10);
         end
         2'h2: begin
            cyc(30);
            chk(user_mode, 1'b0);
            wait_um(30);
         end
         default: begin
            cyc(40);
            chk(user_mode, 1'b0);
            host.falls(1);
            cyc(4);
            chk(user_mode, 1'b0);
            host.falls(1);
            wait_um(8);
         end
      endcase
      chk(user_mode, 1'b1);
      chk(init_complete_line_n_oe, 1'b0);
      chk(device_status_line_n_in, 1'b1);
      chk(configuration_done_line_in, 1'b1);
      chk(user_io_enable, opt[3]);
      host.falls(3);
      cyc(2);
      chk(user_mode, 1'b1);
      chk(user_io_bit, opt[3] & serial_config_bit);
      chk(8'(got.size()), 8'(NW));
      for (i = 0; i < NW; i++) chk(got[i], wval(i, opt));
   endtask
   task automatic t_reconfig();
      int k;
      fork
         host.request();
         begin
            cyc(15);
            chk(configuration_done_line_oe, 1'b1);
            chk(device_status_line_n_oe, 1'b1);
            chk(user_mode, 1'b0);
         end
      join
      for (k = 0; k < SLC + 8 && device_status_line_n_in !== 1'b1; k++) cyc(1);
      chk(device_status_line_n_in, 1'b1);
      chk(config_error, 1'b0);
   endtask
   task automatic t_partial();
      int i;
      host.wait_ready();
      for (i = 0; i < NW - 1; i++) host.send_word(wval(i, 4'h0));
      cyc(40);
      chk(configuration_done_line_oe, 1'b1);
      chk(user_mode, 1'b0);
      t_reconfig();
   endtask
   task automatic t_overflow();
      int i;
      host.wait_ready();
      hold_sink = 1'b1;
      for (i = 0; i < 3; i++) host.send_word(wval(i, 4'h0));
      cyc(2);
      chk(config_error, 1'b1);
      chk(device_status_line_n_oe, 1'b1);
      chk(cfg_valid, 1'b1);
      chk(cfg_data, wval(0, 4'h0));
      hold_sink = 1'b0;
      t_reconfig();
   endtask
   task automatic print_verdict();
      $display("errors %0d, checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #1000000;
      n_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      #1 reset = 1'b0;
      t_power_up();
      t_config(4'hC);
      t_reconfig();
      t_config(4'h3);
      t_reconfig();
      t_config(4'h1);
      t_reconfig();
      t_config(4'hE);
      t_reconfig();
      t_partial();
      t_overflow();
      print_verdict();
   end
endmodule
